// *** logic/aer_mask_log.sv ***
// Correctable error mask, capability and control, and header log register bank
`timescale 1ns/1ps
// Contract
// - Masked correctable error sets no status, no message, no log, no pointer.
// - Correctable mask resets to 00002000h, advisory non-fatal masked.
// - Mask bits 13, 12, 8, 7, 6 and 0 are read-write.
// - Mask reserved bits 31:14, 11:9, 5:1 read zero, ignore writes.
// - Writable mask, CRC enables, first pointer reset on cold resets.
// - Control bit 8 enables end-to-end CRC checking of received packets.
// - Control bit 7 reads one, check ability.
// - Control bit 6 enables end-to-end CRC generation on sent packets.
// - Control bit 5 reads one, generate ability.
// - Bits 4:0 hold hardware pointer to first uncorrectable error position.
// - Control register resets to 000000a0h, bits 31:9 read zero.
// - Header log captures header of most recent unmasked error packet.
// - Header log is four read-only words from 11ch to 128h.
// - Earliest transmitted byte of each word sits in lowest byte lane.
// - Header log clears only on cold resets, survives any other.
// - Each mask bit gates the status bit at the same position.
module aer_mask_log
(
    input wire logic MCLK, // 100 MHz block clock
    input wire logic SYS_RST, // Cold reset: fundamental, global or power-on
    input aer_pkg::cfg_req_s CFG_REQ, // Configuration access, one cycle each
    output logic [31:0] CFG_RDATA, // Read data, valid with CFG_RDVALID
    output logic CFG_RDVALID, // Read answer strobe
    input wire logic [31:0] CORR_EVT, // Correctable error pulses by bit position
    input wire logic CORR_HDR_VALID, // CORR_HDR holds the offending packet header
    input aer_pkg::tlp_hdr_s CORR_HDR, // Header of the correctable error packet
    input wire logic UNC_EVT, // Unmasked uncorrectable error pulse
    input wire logic [4:0] UNC_POS, // Its bit position in uncorrectable status
    input wire logic UNC_PTR_FREE, // No error is held at the pointed position
    input wire logic UNC_HDR_VALID, // UNC_HDR holds the offending packet header
    input aer_pkg::tlp_hdr_s UNC_HDR, // Header of the uncorrectable error packet
    output logic [31:0] CORR_STATUS_SET, // Status set pulses, gated by the mask
    output logic CORR_MSG_REQ, // Correctable error message request pulse
    output logic [31:0] CORR_MASK, // Current mask to the status block
    output logic END_CRC_CHECK_EN, // Check end-to-end CRC on received packets
    output logic END_CRC_GEN_EN, // Generate end-to-end CRC on sent packets
    output logic [4:0] FIRST_ERR_PTR // First error pointer
);

    logic [31:0] mask_reg;
    logic [31:0] mask_next;
    logic check_en_reg;
    logic check_en_next;
    logic gen_en_reg;
    logic gen_en_next;
    logic [4:0] ptr_reg;
    logic [4:0] ptr_next;
    logic [31:0] set_reg;
    logic [31:0] set_next;
    logic msg_reg;
    logic msg_next;
    logic rdvalid_reg;
    logic rdvalid_next;
    logic rd_hdr_reg;
    logic rd_hdr_next;
    logic [31:0] rd_reg;
    logic [31:0] rd_next;

    logic [31:0] lane_bits;
    logic [31:0] mask_wbits;
    logic [31:0] mask_wr_ones;
    logic [31:0] report;
    logic [31:0] cap_ctrl_view;
    logic mask_sel;
    logic ctrl_sel;
    logic hdr_sel;
    logic [1:0] hdr_idx;
    logic corr_hdr_load;
    logic hdr_load;
    aer_pkg::hdr_words_t hdr_words;
    logic [31:0] hdr_rdata;

    // Byte enables spread to bit lanes
    assign lane_bits = {{8{CFG_REQ.be[3]}}, {8{CFG_REQ.be[2]}},
                        {8{CFG_REQ.be[1]}}, {8{CFG_REQ.be[0]}}};

    assign mask_sel = CFG_REQ.addr == aer_pkg::OFF_CORR_MASK;
    assign ctrl_sel = CFG_REQ.addr == aer_pkg::OFF_CAP_CTRL;
    assign hdr_sel = (CFG_REQ.addr == aer_pkg::OFF_HDR_WORD0)
                   | (CFG_REQ.addr == aer_pkg::OFF_HDR_WORD1)
                   | (CFG_REQ.addr == aer_pkg::OFF_HDR_WORD2)
                   | (CFG_REQ.addr == aer_pkg::OFF_HDR_WORD3);
    assign hdr_idx = 2'(({20'h00000, CFG_REQ.addr} - {20'h00000, aer_pkg::OFF_HDR_WORD0}) >> 2);

    // Only the writable mask bits can take a write
    assign mask_wbits = (CFG_REQ.wr && mask_sel) ?
                        (lane_bits & aer_pkg::CORR_MASK_RW_BITS) : 32'h00000000;
    assign mask_wr_ones = mask_wbits & CFG_REQ.wdata;

    genvar g;
    generate
        for (g = 0; g < aer_pkg::CORR_CLASS_COUNT; g = g + 1)
        begin : g_class
            corr_gate u_gate
            (
                .event_in(CORR_EVT[aer_pkg::CORR_CLASS_POS[g]]),
                .mask_in(mask_reg[aer_pkg::CORR_CLASS_POS[g]]),
                .mask_wr_one(mask_wr_ones[aer_pkg::CORR_CLASS_POS[g]]),
                .report_out(report[aer_pkg::CORR_CLASS_POS[g]])
            );
        end
    endgenerate

    // Positions without an error class never report
    assign report[31:14] = 18'h00000;
    assign report[11:9] = 3'h0;
    assign report[5:1] = 5'h00;

    // A header arriving with a masked-only error is dropped, never logged
    assign corr_hdr_load = CORR_HDR_VALID && (report != 32'h00000000);
    assign hdr_load = corr_hdr_load || (UNC_EVT && UNC_HDR_VALID);

    // Uncorrectable header wins when both arrive together
    always_comb
    begin
        hdr_words = '0;
        for (int w = 0; w < aer_pkg::HDR_WORDS; w = w + 1)
        begin
            for (int b = 0; b < 4; b = b + 1)
            begin
                if (UNC_EVT && UNC_HDR_VALID)
                begin
                    hdr_words[w][b*8 +: 8] = UNC_HDR.bytes[w*4 + b];
                end
                else
                begin
                    hdr_words[w][b*8 +: 8] = CORR_HDR.bytes[w*4 + b];
                end
            end
        end
    end

    hdr_store u_hdr_store
    (
        .clk(MCLK),
        .rst(SYS_RST),
        .wr_en(hdr_load),
        .wr_words(hdr_words),
        .rd_idx(hdr_idx),
        .rd_data(hdr_rdata)
    );

    assign cap_ctrl_view = {23'h000000, check_en_reg, 1'b1, gen_en_reg, 1'b1, ptr_reg}
                         | aer_pkg::CAP_CTRL_FIXED_ONES;

    // Register state
    always_comb
    begin
        mask_next = (mask_reg & ~mask_wbits) | (CFG_REQ.wdata & mask_wbits);
        check_en_next = check_en_reg;
        gen_en_next = gen_en_reg;
        if (CFG_REQ.wr && ctrl_sel && CFG_REQ.be[1])
        begin
            check_en_next = CFG_REQ.wdata[aer_pkg::END_CRC_CHECK_ENABLE_POS];
        end
        if (CFG_REQ.wr && ctrl_sel && CFG_REQ.be[0])
        begin
            gen_en_next = CFG_REQ.wdata[aer_pkg::END_CRC_GENERATE_ENABLE_POS];
        end
        // Writes to the pointer and the header log are ignored
        ptr_next = ptr_reg;
        if (UNC_EVT && UNC_PTR_FREE)
        begin
            ptr_next = UNC_POS;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            mask_reg <= aer_pkg::CORR_MASK_RESET;
            check_en_reg <= aer_pkg::CAP_CTRL_RESET[aer_pkg::END_CRC_CHECK_ENABLE_POS];
            gen_en_reg <= aer_pkg::CAP_CTRL_RESET[aer_pkg::END_CRC_GENERATE_ENABLE_POS];
            ptr_reg <= aer_pkg::FIRST_ERR_PTR_RESET;
        end
        else
        begin
            mask_reg <= mask_next;
            check_en_reg <= check_en_next;
            gen_en_reg <= gen_en_next;
            ptr_reg <= ptr_next;
        end
    end

    // Reporting state: one-cycle pulses, nothing held pending while masked
    always_comb
    begin
        set_next = report;
        msg_next = report != 32'h00000000;
    end

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            set_reg <= 32'h00000000;
            msg_reg <= 1'b0;
        end
        else
        begin
            set_reg <= set_next;
            msg_reg <= msg_next;
        end
    end

    // Read state; header words come from the store's own output register
    always_comb
    begin
        rdvalid_next = CFG_REQ.rd;
        rd_hdr_next = CFG_REQ.rd && hdr_sel;
        rd_next = 32'h00000000;
        if (CFG_REQ.rd && mask_sel)
        begin
            rd_next = mask_reg & aer_pkg::CORR_MASK_RW_BITS;
        end
        else if (CFG_REQ.rd && ctrl_sel)
        begin
            rd_next = cap_ctrl_view;
        end
    end

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            rdvalid_reg <= 1'b0;
            rd_hdr_reg <= 1'b0;
            rd_reg <= 32'h00000000;
        end
        else
        begin
            rdvalid_reg <= rdvalid_next;
            rd_hdr_reg <= rd_hdr_next;
            rd_reg <= rd_next;
        end
    end

    assign CFG_RDATA = rd_hdr_reg ? hdr_rdata : rd_reg;
    assign CFG_RDVALID = rdvalid_reg;
    assign CORR_STATUS_SET = set_reg;
    assign CORR_MSG_REQ = msg_reg;
    assign CORR_MASK = mask_reg;
    assign END_CRC_CHECK_EN = check_en_reg;
    assign END_CRC_GEN_EN = gen_en_reg;
    assign FIRST_ERR_PTR = ptr_reg;

    logic [31:0] eff_mask;
    assign eff_mask = mask_reg | mask_wr_ones;
    logic [31:0] unmasked_evt;
    assign unmasked_evt = CORR_EVT & ~eff_mask & aer_pkg::CORR_MASK_RW_BITS;

    a_masked_no_report: assert property (@(posedge MCLK) disable iff (SYS_RST)
        ((CORR_EVT & eff_mask & aer_pkg::CORR_MASK_RW_BITS) != 32'h00000000
         && (CORR_EVT & ~eff_mask & aer_pkg::CORR_MASK_RW_BITS) == 32'h00000000)
        |=> CORR_STATUS_SET == 32'h00000000 && !CORR_MSG_REQ)
        else $error("masked correctable error was reported");

    a_masked_no_log: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (report == 32'h00000000 && !(UNC_EVT && UNC_HDR_VALID)) |-> !hdr_load)
        else $error("header log loaded without an unmasked error");

    a_unmasked_sets: assert property (@(posedge MCLK) disable iff (SYS_RST)
        1'b1 |=> CORR_STATUS_SET ==
            $past(unmasked_evt))
        else $error("status set does not follow unmasked error");

    a_same_cycle_mask: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (CORR_EVT[aer_pkg::BAD_TRANSACTION_PACKET_MASK_POS]
         && mask_wr_ones[aer_pkg::BAD_TRANSACTION_PACKET_MASK_POS])
        |=> !CORR_STATUS_SET[aer_pkg::BAD_TRANSACTION_PACKET_MASK_POS])
        else $error("error reported while its mask was written");

    a_mask_reserved: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (mask_reg & ~aer_pkg::CORR_MASK_RW_BITS) == 32'h00000000)
        else $error("reserved mask bit is set");

    a_mask_write: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (CFG_REQ.wr && mask_sel && CFG_REQ.be[1])
        |=> CORR_MASK[aer_pkg::REPLAY_EXPIRY_MASK_POS]
            == $past(CFG_REQ.wdata[aer_pkg::REPLAY_EXPIRY_MASK_POS]))
        else $error("replay expiry mask did not take write");

    sequence s_ctrl_read;
        CFG_REQ.rd && ctrl_sel;
    endsequence

    a_ctrl_read_view: assert property (@(posedge MCLK) disable iff (SYS_RST)
        s_ctrl_read |=> CFG_RDVALID && CFG_RDATA[7] && CFG_RDATA[5]
            && CFG_RDATA[31:9] == 23'h000000 && CFG_RDATA[4:0] == $past(ptr_reg))
        else $error("control read shows wrong fixed or reserved bits");

    a_check_enable: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (CFG_REQ.wr && ctrl_sel && CFG_REQ.be[1])
        |=> END_CRC_CHECK_EN == $past(CFG_REQ.wdata[8]))
        else $error("check enable did not follow write");

    a_gen_enable: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (CFG_REQ.wr && ctrl_sel && CFG_REQ.be[0])
        |=> END_CRC_GEN_EN == $past(CFG_REQ.wdata[6]))
        else $error("generate enable did not follow write");

    a_ptr_hold: assert property (@(posedge MCLK) disable iff (SYS_RST)
        !(UNC_EVT && UNC_PTR_FREE) |=> FIRST_ERR_PTR == $past(FIRST_ERR_PTR))
        else $error("first error pointer moved without a free error");

    a_ptr_load: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (UNC_EVT && UNC_PTR_FREE) |=> FIRST_ERR_PTR == $past(UNC_POS))
        else $error("first error pointer not loaded");

    a_read_latency: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (CFG_REQ.rd && !hdr_sel && !mask_sel && !ctrl_sel)
        |=> CFG_RDVALID && CFG_RDATA == 32'h00000000)
        else $error("unmapped read did not return zero");

    a_msg_follows: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (unmasked_evt != 32'h00000000) |=> CORR_MSG_REQ)
        else $error("unmasked correctable error raised no message");

    a_no_event_quiet: assert property (@(posedge MCLK) disable iff (SYS_RST)
        (unmasked_evt == 32'h00000000) |=> !CORR_MSG_REQ)
        else $error("message raised without an unmasked error");

    sequence s_any_read;
        CFG_REQ.rd;
    endsequence

    a_read_answer: assert property (@(posedge MCLK) disable iff (SYS_RST)
        s_any_read |=> CFG_RDVALID)
        else $error("read gave no answer strobe");

    a_enables_hold: assert property (@(posedge MCLK) disable iff (SYS_RST)
        !(CFG_REQ.wr && ctrl_sel) |=> $stable(END_CRC_CHECK_EN) && $stable(END_CRC_GEN_EN))
        else $error("crc enable moved without a control write");

endmodule // aer_mask_log

// *** logic/aer_pkg.sv ***
// Shared constants and carrier types for the correctable mask and header log bank
package aer_pkg;

    // Register byte offsets in extended configuration space
    localparam logic [11:0] OFF_CORR_MASK = 12'h114;
    localparam logic [11:0] OFF_CAP_CTRL = 12'h118;
    localparam logic [11:0] OFF_HDR_WORD0 = 12'h11c;
    localparam logic [11:0] OFF_HDR_WORD1 = 12'h120;
    localparam logic [11:0] OFF_HDR_WORD2 = 12'h124;
    localparam logic [11:0] OFF_HDR_WORD3 = 12'h128;

    // Correctable mask field positions
    localparam int unsigned RECEIVER_ERROR_MASK_POS = 0;
    localparam int unsigned BAD_TRANSACTION_PACKET_MASK_POS = 6;
    localparam int unsigned BAD_LINK_PACKET_MASK_POS = 7;
    localparam int unsigned REPLAY_ROLLOVER_MASK_POS = 8;
    localparam int unsigned REPLAY_EXPIRY_MASK_POS = 12;
    localparam int unsigned ADVISORY_NONFATAL_MASK_POS = 13;
    localparam int unsigned CORR_CLASS_COUNT = 6;
    localparam int unsigned CORR_CLASS_POS [CORR_CLASS_COUNT] = '{0, 6, 7, 8, 12, 13};

    // Correctable mask reset and writable bits
    localparam logic [31:0] CORR_MASK_RESET = 32'h00002000;
    localparam logic [31:0] CORR_MASK_RW_BITS = 32'h000031c1;

    // Capability and control field positions
    localparam int unsigned END_CRC_CHECK_ENABLE_POS = 8;
    localparam int unsigned END_CRC_CHECK_ABILITY_POS = 7;
    localparam int unsigned END_CRC_GENERATE_ENABLE_POS = 6;
    localparam int unsigned END_CRC_GENERATE_ABILITY_POS = 5;
    localparam int unsigned FIRST_ERR_PTR_LSB = 0;
    localparam int unsigned FIRST_ERR_PTR_WIDTH = 5;

    // Capability and control reset value and its fixed one bits
    localparam logic [31:0] CAP_CTRL_RESET = 32'h000000a0;
    localparam logic [31:0] CAP_CTRL_FIXED_ONES = 32'h000000a0;
    localparam logic [4:0] FIRST_ERR_PTR_RESET = 5'h00;
    localparam logic [31:0] HDR_LOG_RESET = 32'h00000000;
    localparam int unsigned HDR_WORDS = 4;

    // Configuration access from the upstream side
    typedef struct packed {
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } cfg_req_s;

    // Packet header bytes, index 0 is the earliest transmitted byte
    typedef struct packed {
        logic [15:0][7:0] bytes;
    } tlp_hdr_s;

    // Header as stored, one 32-bit word per slot
    typedef logic [HDR_WORDS-1:0][31:0] hdr_words_t;

endpackage

// *** logic/corr_gate.sv ***
// One correctable error class gated by its mask bit
`timescale 1ns/1ps
module corr_gate
(
    input wire logic event_in, // Error of this class detected
    input wire logic mask_in, // Stored mask bit
    input wire logic mask_wr_one, // A one is being written to the mask bit
    output logic report_out // Unmasked error, to be reported
);

    // A mask being set in the same cycle already wins over the error
    assign report_out = event_in & ~mask_in & ~mask_wr_one;

endmodule // corr_gate

// *** logic/hdr_store.sv ***
// Four-word header log storage with registered read port
`timescale 1ns/1ps
module hdr_store
(
    input wire logic clk, // Block clock
    input wire logic rst, // Cold reset, active high
    input wire logic wr_en, // Capture all words
    input aer_pkg::hdr_words_t wr_words, // Words to capture
    input wire logic [1:0] rd_idx, // Word to read
    output logic [31:0] rd_data // Registered read data
);

    aer_pkg::hdr_words_t mem_reg;
    aer_pkg::hdr_words_t mem_next;
    logic [31:0] rd_data_next;

    always_comb
    begin
        mem_next = mem_reg;
        if (wr_en)
        begin
            mem_next = wr_words;
        end
        rd_data_next = mem_reg[rd_idx];
    end

    // Only the cold reset clears the log; no other reset reaches here
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mem_reg <= {aer_pkg::HDR_WORDS{aer_pkg::HDR_LOG_RESET}};
            rd_data <= aer_pkg::HDR_LOG_RESET;
        end
        else
        begin
            mem_reg <= mem_next;
            rd_data <= rd_data_next;
        end
    end

    // Words as last presented and the word they hold at the read index, tracked apart from the store itself
    aer_pkg::hdr_words_t probe_words_reg;
    logic [31:0] probe_word_reg;

    always_ff @(posedge clk)
    begin
        probe_words_reg <= wr_words;
        probe_word_reg <= probe_words_reg[rd_idx];
    end

    sequence s_load;
        wr_en;
    endsequence

    sequence s_read_idle;
        !wr_en;
    endsequence

    a_hdr_load_read: assert property (@(posedge clk) disable iff (rst)
        s_load ##1 s_read_idle |=> rd_data == probe_word_reg)
        else $error("header log read does not return captured word");

endmodule // hdr_store

// *** logic/aer_mask_log_fix.sv ***
// Holds no design unit

// *** testbench/cfg_host_model.sv ***
// Upstream configuration requester model driving the bank's access port
`timescale 1ns/1ps
module cfg_host_model
(
    input wire logic clk, // Block clock
    input wire logic [31:0] rdata, // Read data from the bank
    input wire logic rdvalid, // Read answer strobe
    output aer_pkg::cfg_req_s req // Configuration request
);
    initial req = '{wr: 1'b0, rd: 1'b0, addr: 12'h000, be: 4'h0, wdata: 32'h00000000};

    // Qualifiers drop and address, enables and data are inverted so a stale value is never mistaken for a live one
    task automatic release_bus();
        req.wr = 1'b0;
        req.rd = 1'b0;
        req.addr = ~req.addr;
        req.be = ~req.be;
        req.wdata = ~req.wdata;
    endtask

    task automatic cfg_write(input logic [11:0] addr, input logic [3:0] be,
        input logic [31:0] data);
        @(negedge clk);
        req.wr = 1'b1;
        req.addr = addr;
        req.be = be;
        req.wdata = data;
        @(negedge clk);
        release_bus();
    endtask

    // Answer comes one cycle after the request edge and is sampled before it goes
    task automatic cfg_read(input logic [11:0] addr, output logic [31:0] data,
        output logic valid);
        @(negedge clk);
        req.rd = 1'b1;
        req.addr = addr;
        req.be = 4'hf;
        @(negedge clk);
        data = rdata;
        valid = rdvalid;
        release_bus();
    endtask
endmodule // cfg_host_model

// *** testbench/aer_mask_log_tb_top.sv ***
// Self-checking testbench for the correctable mask, control and header log bank
`timescale 1ns/1ps
module aer_mask_log_tb_top;
    logic mclk = 1'b0;
    logic sys_rst;
    aer_pkg::cfg_req_s cfg_req;
    logic [31:0] cfg_rdata;
    logic cfg_rdvalid;
    logic [31:0] corr_evt;
    logic corr_hdr_valid;
    aer_pkg::tlp_hdr_s corr_hdr;
    logic unc_evt;
    logic [4:0] unc_pos;
    logic unc_ptr_free;
    logic unc_hdr_valid;
    aer_pkg::tlp_hdr_s unc_hdr;
    logic [31:0] corr_status_set;
    logic corr_msg_req;
    logic [31:0] corr_mask;
    logic end_crc_check_en;
    logic end_crc_gen_en;
    logic [4:0] first_err_ptr;
    int err_total = 0;
    int check_count = 0;

    always #5 mclk = ~mclk;

    aer_mask_log dut_u (.MCLK(mclk), .SYS_RST(sys_rst), .CFG_REQ(cfg_req),
        .CFG_RDATA(cfg_rdata), .CFG_RDVALID(cfg_rdvalid), .CORR_EVT(corr_evt),
        .CORR_HDR_VALID(corr_hdr_valid), .CORR_HDR(corr_hdr), .UNC_EVT(unc_evt),
        .UNC_POS(unc_pos), .UNC_PTR_FREE(unc_ptr_free), .UNC_HDR_VALID(unc_hdr_valid),
        .UNC_HDR(unc_hdr), .CORR_STATUS_SET(corr_status_set), .CORR_MSG_REQ(corr_msg_req),
        .CORR_MASK(corr_mask), .END_CRC_CHECK_EN(end_crc_check_en),
        .END_CRC_GEN_EN(end_crc_gen_en), .FIRST_ERR_PTR(first_err_ptr));

    cfg_host_model host_u (.clk(mclk), .rdata(cfg_rdata), .rdvalid(cfg_rdvalid), .req(cfg_req));

    task automatic tally_and_finish();
        $display("Checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    function automatic aer_pkg::tlp_hdr_s make_hdr(input logic [7:0] seed);
        aer_pkg::tlp_hdr_s h;
        for (int i = 0; i < 16; i++)
            h.bytes[i] = seed + 8'(i);
        return h;
    endfunction

    // Earliest byte of each word lands in the lowest lane
    function automatic logic [31:0] exp_word(input logic [7:0] seed, input int k);
        logic [7:0] b0;
        b0 = seed + 8'(4 * k);
        return {b0 + 8'h03, b0 + 8'h02, b0 + 8'h01, b0};
    endfunction

    task automatic rd_check(input string name, input logic [11:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        logic v;
        host_u.cfg_read(addr, d, v);
        check({name, " answer"}, {31'h0, v}, 32'h00000001);
        check(name, d, exp);
    endtask

    task automatic hdr_check(input logic [7:0] seed);
        for (int k = 0; k < 4; k++)
            rd_check("header word", aer_pkg::OFF_HDR_WORD0 + 12'(4 * k), exp_word(seed, k));
    endtask

    task automatic evt_check(input logic [31:0] exp_set, input logic exp_msg);
        check("status set", corr_status_set, exp_set);
        check("message", {31'h0, corr_msg_req}, {31'h0, exp_msg});
    endtask

    task automatic corr_pulse(input int pos, input logic hv, input logic [7:0] seed);
        @(negedge mclk);
        corr_evt = 32'h00000001 << pos;
        corr_hdr_valid = hv;
        corr_hdr = make_hdr(seed);
        @(negedge mclk);
        corr_evt = 32'h00000000;
        corr_hdr_valid = 1'b0;
        corr_hdr = make_hdr(~seed);
    endtask

    task automatic unc_pulse(input logic [4:0] pos, input logic free, input logic hv,
        input logic [7:0] seed);
        @(negedge mclk);
        unc_evt = 1'b1;
        unc_pos = pos;
        unc_ptr_free = free;
        unc_hdr_valid = hv;
        unc_hdr = make_hdr(seed);
        @(negedge mclk);
        unc_evt = 1'b0;
        unc_pos = ~pos;
        unc_hdr_valid = 1'b0;
        unc_hdr = make_hdr(~seed);
    endtask

    task automatic t_reset_values();
        check("mask out", corr_mask, 32'h00002000);
        check("crc enables", {30'h0, end_crc_check_en, end_crc_gen_en}, 32'h0);
        check("pointer", {27'h0, first_err_ptr}, 32'h0);
        rd_check("mask reg", aer_pkg::OFF_CORR_MASK, 32'h00002000);
        rd_check("control reg", aer_pkg::OFF_CAP_CTRL, 32'h000000a0);
        for (int k = 0; k < 4; k++)
            rd_check("header clear", aer_pkg::OFF_HDR_WORD0 + 12'(4 * k), 32'h00000000);
    endtask

    task automatic t_mask_rw();
        host_u.cfg_write(aer_pkg::OFF_CORR_MASK, 4'hf, 32'hffffffff);
        rd_check("mask all ones", aer_pkg::OFF_CORR_MASK, 32'h000031c1);
        check("mask out", corr_mask, 32'h000031c1);
        host_u.cfg_write(aer_pkg::OFF_CORR_MASK, 4'hf, 32'h00000000);
        host_u.cfg_write(aer_pkg::OFF_CORR_MASK, 4'h2, 32'hffffffff);
        rd_check("mask byte one", aer_pkg::OFF_CORR_MASK, 32'h00003100);
        host_u.cfg_write(aer_pkg::OFF_CORR_MASK, 4'hf, 32'h00000000);
        rd_check("mask cleared", aer_pkg::OFF_CORR_MASK, 32'h00000000);
        host_u.cfg_write(12'h110, 4'hf, 32'hffffffff);
        rd_check("mask after status clear", aer_pkg::OFF_CORR_MASK, 32'h00000000);
        rd_check("unmapped", 12'h200, 32'h00000000);
    endtask

    task automatic t_ctrl_rw();
        host_u.cfg_write(aer_pkg::OFF_CAP_CTRL, 4'hf, 32'hffffffff);
        rd_check("control ones", aer_pkg::OFF_CAP_CTRL, 32'h000001e0);
        check("enables on", {30'h0, end_crc_check_en, end_crc_gen_en}, 32'h3);
        host_u.cfg_write(aer_pkg::OFF_CAP_CTRL, 4'h1, 32'h00000000);
        rd_check("gen cleared", aer_pkg::OFF_CAP_CTRL, 32'h000001a0);
        check("enables check only", {30'h0, end_crc_check_en, end_crc_gen_en}, 32'h2);
        host_u.cfg_write(aer_pkg::OFF_CAP_CTRL, 4'hf, 32'h00000000);
        rd_check("control zero", aer_pkg::OFF_CAP_CTRL, 32'h000000a0);
    endtask

    task automatic t_classes();
        for (int i = 0; i < aer_pkg::CORR_CLASS_COUNT; i++)
        begin
            corr_pulse(aer_pkg::CORR_CLASS_POS[i], 1'b1, 8'(16 * i));
            evt_check(32'h00000001 << aer_pkg::CORR_CLASS_POS[i], 1'b1);
            hdr_check(8'(16 * i));
        end
        corr_pulse(0, 1'b0, 8'hee);
        evt_check(32'h00000001, 1'b1);
        hdr_check(8'h50);
        host_u.cfg_write(aer_pkg::OFF_CORR_MASK, 4'hf, 32'h000031c1);
        for (int i = 0; i < aer_pkg::CORR_CLASS_COUNT; i++)
        begin
            corr_pulse(aer_pkg::CORR_CLASS_POS[i], 1'b1, 8'hc0);
            evt_check(32'h00000000, 1'b0);
        end
        hdr_check(8'h50);
    endtask

    task automatic t_same_cycle();
        host_u.cfg_write(aer_pkg::OFF_CORR_MASK, 4'hf, 32'h00000000);
        fork
            host_u.cfg_write(aer_pkg::OFF_CORR_MASK, 4'h1, 32'h00000040);
            corr_pulse(aer_pkg::BAD_TRANSACTION_PACKET_MASK_POS, 1'b1, 8'h77);
        join
        evt_check(32'h00000000, 1'b0);
        host_u.cfg_write(aer_pkg::OFF_CORR_MASK, 4'hf, 32'h00000000);
        evt_check(32'h00000000, 1'b0);
        @(negedge mclk);
        evt_check(32'h00000000, 1'b0);
        hdr_check(8'h50);
    endtask

    task automatic t_pointer();
        unc_pulse(5'h13, 1'b1, 1'b1, 8'h90);
        check("pointer set", {27'h0, first_err_ptr}, 32'h00000013);
        rd_check("control pointer", aer_pkg::OFF_CAP_CTRL, 32'h000000b3);
        hdr_check(8'h90);
        unc_pulse(5'h04, 1'b0, 1'b0, 8'h30);
        check("pointer held", {27'h0, first_err_ptr}, 32'h00000013);
        host_u.cfg_write(aer_pkg::OFF_CAP_CTRL, 4'hf, 32'h0000001f);
        host_u.cfg_write(aer_pkg::OFF_HDR_WORD0, 4'hf, 32'h12345678);
        rd_check("pointer read only", aer_pkg::OFF_CAP_CTRL, 32'h000000b3);
        hdr_check(8'h90);
    endtask

    task automatic t_cold_reset();
        host_u.cfg_write(aer_pkg::OFF_CORR_MASK, 4'hf, 32'h000011c1);
        host_u.cfg_write(aer_pkg::OFF_CAP_CTRL, 4'hf, 32'h00000140);
        @(negedge mclk);
        sys_rst = 1'b1;
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        t_reset_values();
    endtask

    initial
    begin
        #50000;
        err_total++;
        tally_and_finish();
    end

    initial
    begin
        sys_rst = 1'b1;
        corr_evt = 32'h00000000;
        corr_hdr_valid = 1'b0;
        corr_hdr = make_hdr(8'h00);
        unc_evt = 1'b0;
        unc_pos = 5'h00;
        unc_ptr_free = 1'b0;
        unc_hdr_valid = 1'b0;
        unc_hdr = make_hdr(8'h00);
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        sys_rst = 1'b0;
        t_reset_values();
        t_mask_rw();
        t_ctrl_rw();
        t_classes();
        t_same_cycle();
        t_pointer();
        t_cold_reset();
        tally_and_finish();
    end
endmodule // aer_mask_log_tb_top
